// ### core/fspc_pkg.sv
package fspc_pkg;
	// ---------------------------------------------------------------
	// Array geometry
	// ---------------------------------------------------------------
	localparam int ROW_WORDS = 64;
	localparam int ROW_BYTES = 192;
	localparam int BLK_ROWS = 8;
	localparam int BLK_WORDS = 512;
	localparam int BLK_BYTES = 1536;
	localparam int ADDR_W = 24;
	localparam int WORD_W = 24;
	localparam logic [23:0] ROW_ALIGN_MASK = 24'hffff80;
	localparam logic [23:0] BLK_ALIGN_MASK = 24'hfffc00;
	localparam logic [23:0] ADDR_STEP = 24'h000002;
	localparam logic [23:0] ERASED_WORD = 24'hffffff;
	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int START_POS = 15;
	localparam int PROGRAM_ERASE_ENABLE_POS = 14;
	localparam int ERR_POS = 13;
	localparam int ERASE_POS = 6;
	localparam int OP_W = 4;
	localparam logic CTRL_RESET = 1'b0;
	localparam logic [3:0] OP_RESET = 4'h0;
	localparam logic [3:0] OP_BULK = 4'hf;
	localparam logic [3:0] OP_ROW_ERASE = 4'h2;
	localparam logic [3:0] OP_ROW_PROG = 4'h1;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] CONFIG_PAGE_BIT = 8'h80;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int OP_TIME_US = 4000;
	localparam int CLK_KHZ = 125000;
	localparam int OP_CYCLES = OP_TIME_US * (CLK_KHZ / 1000);
	// ---------------------------------------------------------------
	// Commands and jobs
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_RD_LOW = 3'h0,
		CMD_RD_HIGH = 3'h1,
		CMD_WR_LOW = 3'h2,
		CMD_WR_HIGH = 3'h3,
		CMD_CTRL_WR = 3'h4,
		CMD_CTRL_RD = 3'h5,
		CMD_KEY_WR = 3'h6,
		CMD_PAGE_WR = 3'h7
	} fspc_cmd_t;
	typedef enum logic [3:0] {
		JOB_READ = 4'h1,
		JOB_BLK = 4'h2,
		JOB_ALL = 4'h4,
		JOB_PROG = 4'h8
	} fspc_job_t;
endpackage

// ### core/fspc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fspc_if;
	logic cmdValid;
	logic cmdReady;
	fspc_pkg::fspc_cmd_t cmdOp;
	logic [15:0] cmdAddr;
	logic cmdByte;
	logic [15:0] cmdData;
	logic rspValid;
	logic [15:0] rspData;
	modport dev (
		input cmdValid, cmdOp, cmdAddr, cmdByte, cmdData,
		output cmdReady, rspValid, rspData
	);
	modport host (
		output cmdValid, cmdOp, cmdAddr, cmdByte, cmdData,
		input cmdReady, rspValid, rspData
	);
endinterface
`default_nettype wire

// ### core/fspc_dev.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Array rows of 64 words, 192 bytes
// - Erase eight-row blocks, aligned from memory start
// - 64-word holding buffer indexed by the low six word-address bits
// - Host loads one aligned 64-word group only
// - Target address is page byte plus EA
// - Low table ops reach bits 15:0
// - High table ops reach bits 23:16
// - Table writes fill buffer only, two cycles
// - Host loads 64 words, programs each row
// - Write-only key, 55h then AAh
// - Operation lasts 4 ms, processor stalls
// - Start bit set-only, cleared when done
// - Write-enable bit gates program and erase
// - Error flag marks improper start or abort
// - Erase-select picks erase or program
// - Op codes: bulk, block erase, row program
// - Other op codes are unimplemented
// - Unused control bits read zero
// - Control bits cleared by power-on only
// - Program window mapping paused during table ops
module fspc_dev #(
	parameter int ARRAY_ROWS = 16,
	parameter int OP_CYCLES = fspc_pkg::OP_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic softRst,
	fspc_if.dev bus,
	output logic mapSuspend,
	output logic cpuStall
);
	import fspc_pkg::*;

	localparam int ARRAY_WORDS = ARRAY_ROWS * ROW_WORDS;
	localparam int AW = $clog2(ARRAY_WORDS);
	localparam int CNT_W = $clog2(OP_CYCLES + 1);

	generate
		if (ARRAY_ROWS < BLK_ROWS || ARRAY_ROWS % BLK_ROWS != 0 || OP_CYCLES < 1) begin : g_bad
			$error("fspc_dev: array must hold whole erase blocks and OP_CYCLES must be positive");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ANS = 3'h2,
		ST_BUSY = 3'h4
	} fspc_state_t;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [WORD_W-1:0] flashMem [ARRAY_WORDS];
	logic [WORD_W-1:0] holdBuf [ROW_WORDS];

	fspc_state_t state_r, state_nxt;
	logic [7:0] page_r;
	logic start_r, start_nxt;
	logic program_erase_enable_r, program_erase_enable_nxt;
	logic err_r, err_nxt;
	logic erase_r, erase_nxt;
	logic [3:0] op_r, op_nxt;
	logic keyStage_r, keyStage_nxt;
	logic armed_r, armed_nxt;
	logic launchPend_r;
	logic tblPend_r;
	logic [22:0] tgtWord_r;
	logic [CNT_W-1:0] cnt_r;
	logic [15:0] rspData_r;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] tblRead(input logic high, input logic byteMode, input logic sel,
			input logic [23:0] w);
		logic [15:0] v;
		v = high ? {8'h00, w[23:16]} : w[15:0];
		// Phantom upper byte of the high word reads zero
		if (byteMode) begin
			v = sel ? {8'h00, v[15:8]} : {8'h00, v[7:0]};
		end
		return v;
	endfunction

	function automatic logic opValid(input logic er, input logic [3:0] op);
		return er ? (op == OP_BULK || op == OP_ROW_ERASE) : (op == OP_ROW_PROG);
	endfunction

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	logic accept, isTbl, userPage, twLow, twHigh, ctrlWr, startReq, keyOk, launch, improper;
	logic abort, finish, inArray;
	logic [23:0] fullAddr;
	logic [22:0] wordIdx;
	logic [5:0] bufIdx;
	logic [23:0] memWord;
	logic [15:0] ctrlVal;

	assign accept = bus.cmdValid && state_r == ST_IDLE;
	assign fullAddr = {page_r, bus.cmdAddr};
	assign wordIdx = fullAddr[23:1];
	assign bufIdx = wordIdx[5:0];
	assign userPage = (page_r & CONFIG_PAGE_BIT) == 8'h00;
	assign isTbl = bus.cmdOp == CMD_RD_LOW || bus.cmdOp == CMD_RD_HIGH
		|| bus.cmdOp == CMD_WR_LOW || bus.cmdOp == CMD_WR_HIGH;
	// Table writes to configuration space are dropped
	assign twLow = accept && userPage && bus.cmdOp == CMD_WR_LOW;
	assign twHigh = accept && userPage && bus.cmdOp == CMD_WR_HIGH;
	assign inArray = userPage && int'(wordIdx) < ARRAY_WORDS;
	assign memWord = inArray ? flashMem[wordIdx[AW-1:0]] : 24'h000000;
	assign ctrlWr = accept && bus.cmdOp == CMD_CTRL_WR;
	assign startReq = ctrlWr && bus.cmdData[START_POS];
	assign keyOk = armed_r && bus.cmdData[PROGRAM_ERASE_ENABLE_POS];
	// Valid key with an unimplemented pairing is a silent no-op
	assign launch = startReq && keyOk
		&& opValid(bus.cmdData[ERASE_POS], bus.cmdData[OP_W-1:0]);
	assign improper = startReq && !keyOk;
	assign abort = softRst && state_r == ST_BUSY;
	assign finish = !softRst && state_r == ST_BUSY && cnt_r == '0;
	assign ctrlVal = {start_r, program_erase_enable_r, err_r, 6'h00, erase_r, 2'h0, op_r};

	assign bus.cmdReady = state_r == ST_IDLE;
	assign bus.rspValid = state_r == ST_ANS;
	assign bus.rspData = rspData_r;
	assign cpuStall = state_r == ST_BUSY;
	assign mapSuspend = (accept && isTbl) || (state_r == ST_ANS && tblPend_r);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (accept) state_nxt = ST_ANS;
			ST_ANS: state_nxt = launchPend_r ? ST_BUSY : ST_IDLE;
			ST_BUSY: if (finish || abort) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_comb begin
		program_erase_enable_nxt = ctrlWr ? bus.cmdData[PROGRAM_ERASE_ENABLE_POS] : program_erase_enable_r;
		erase_nxt = ctrlWr ? bus.cmdData[ERASE_POS] : erase_r;
		op_nxt = ctrlWr ? bus.cmdData[OP_W-1:0] : op_r;
		// Software can only set the start bit, and only through the key
		start_nxt = launch ? 1'b1 : (finish || abort) ? 1'b0 : start_r;
		// Hardware set wins over a software write of zero
		err_nxt = (improper || abort) ? 1'b1 : launch ? 1'b0 : ctrlWr ? bus.cmdData[ERR_POS] : err_r;
		keyStage_nxt = keyStage_r;
		armed_nxt = armed_r;
		if (accept) begin
			// Any other access between key and start breaks the sequence
			keyStage_nxt = bus.cmdOp == CMD_KEY_WR && bus.cmdData[7:0] == KEY_FIRST;
			armed_nxt = bus.cmdOp == CMD_KEY_WR && keyStage_r && bus.cmdData[7:0] == KEY_SECOND;
		end
	end

	// Power-on reset only; soft resets outside an operation leave control bits alone
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_r <= CTRL_RESET;
			program_erase_enable_r <= CTRL_RESET;
			err_r <= CTRL_RESET;
			erase_r <= CTRL_RESET;
			op_r <= OP_RESET;
		end else begin
			start_r <= start_nxt;
			program_erase_enable_r <= program_erase_enable_nxt;
			err_r <= err_nxt;
			erase_r <= erase_nxt;
			op_r <= op_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || softRst) begin
			state_r <= ST_IDLE;
			page_r <= 8'h00;
			keyStage_r <= 1'b0;
			armed_r <= 1'b0;
			launchPend_r <= 1'b0;
			tblPend_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			keyStage_r <= keyStage_nxt;
			armed_r <= armed_nxt;
			launchPend_r <= launch;
			tblPend_r <= accept && isTbl;
			if (accept && bus.cmdOp == CMD_PAGE_WR) begin
				page_r <= bus.cmdData[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tgtWord_r <= 23'h000000;
			cnt_r <= '0;
			rspData_r <= 16'h0000;
		end else begin
			// Last table-write address names the row or block to act on
			if (twLow || twHigh) begin
				tgtWord_r <= wordIdx;
			end
			if (state_r == ST_ANS && launchPend_r) begin
				cnt_r <= CNT_W'(OP_CYCLES - 1);
			end else if (state_r == ST_BUSY && cnt_r != '0) begin
				cnt_r <= cnt_r - 1'b1;
			end
			if (accept) begin
				case (bus.cmdOp)
					CMD_RD_LOW: rspData_r <= tblRead(1'b0, bus.cmdByte, bus.cmdAddr[0], memWord);
					CMD_RD_HIGH: rspData_r <= tblRead(1'b1, bus.cmdByte, bus.cmdAddr[0], memWord);
					CMD_CTRL_RD: rspData_r <= ctrlVal;
					default: rspData_r <= 16'h0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Holding buffer and array
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (twLow) begin
			if (!bus.cmdByte) begin
				holdBuf[bufIdx][15:0] <= bus.cmdData;
			end else if (bus.cmdAddr[0]) begin
				holdBuf[bufIdx][15:8] <= bus.cmdData[7:0];
			end else begin
				holdBuf[bufIdx][7:0] <= bus.cmdData[7:0];
			end
		end
		if (twHigh && !(bus.cmdByte && bus.cmdAddr[0])) begin
			holdBuf[bufIdx][23:16] <= bus.cmdData[7:0];
		end
	end

	// Array changes only at the end, so an aborted operation leaves it intact
	always_ff @(posedge clk_sys) begin
		if (finish) begin
			for (int i = 0; i < ARRAY_WORDS; i++) begin
				if (erase_r && (op_r == OP_BULK || i / BLK_WORDS == int'(tgtWord_r) / BLK_WORDS)) begin
					flashMem[i] <= ERASED_WORD;
				end else if (!erase_r && i / ROW_WORDS == int'(tgtWord_r) / ROW_WORDS) begin
					flashMem[i] <= holdBuf[i % ROW_WORDS];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### core/fspc_host.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_host (
	input wire logic clk_sys,
	input wire logic rst,
	fspc_if.host bus,
	input wire logic jobValid,
	input wire fspc_pkg::fspc_job_t jobKind,
	input wire logic [23:0] jobAddr,
	output logic jobReady,
	input wire logic wordValid,
	input wire logic [23:0] wordData,
	output logic wordReady,
	output logic doneValid,
	output logic [23:0] doneData,
	output logic doneErr
);
	import fspc_pkg::*;

	typedef enum logic [11:0] {
		H_IDLE = 12'h001,
		H_PAGE = 12'h002,
		H_TWL = 12'h004,
		H_TWH = 12'h008,
		H_CFG = 12'h010,
		H_KEY1 = 12'h020,
		H_KEY2 = 12'h040,
		H_GO = 12'h080,
		H_CHK = 12'h100,
		H_RDL = 12'h200,
		H_RDH = 12'h400,
		H_DONE = 12'h800
	} fspc_hstate_t;

	fspc_hstate_t state_r, state_nxt, follow;
	fspc_job_t kind_r;
	logic pend_r;
	logic [23:0] addr_r;
	logic [23:0] data_r;
	logic [5:0] cnt_r;
	logic err_r;
	logic active, needWord, issued, step;

	function automatic logic [15:0] ctrlWord(input fspc_job_t k, input logic go);
		logic [15:0] w;
		w = 16'h0000;
		w[START_POS] = go;
		w[PROGRAM_ERASE_ENABLE_POS] = 1'b1;
		w[ERASE_POS] = k != JOB_PROG;
		w[OP_W-1:0] = k == JOB_ALL ? OP_BULK : k == JOB_BLK ? OP_ROW_ERASE : OP_ROW_PROG;
		return w;
	endfunction

	// ---------------------------------------------------------------
	// Command issue
	// ---------------------------------------------------------------
	assign active = !pend_r && state_r != H_IDLE && state_r != H_DONE;
	assign needWord = state_r == H_TWL && kind_r == JOB_PROG;
	assign bus.cmdValid = active && (!needWord || wordValid);
	assign issued = bus.cmdValid && bus.cmdReady;
	assign wordReady = needWord && issued;
	assign step = pend_r && bus.rspValid;
	assign bus.cmdAddr = addr_r[15:0];
	assign bus.cmdByte = 1'b0;
	assign jobReady = state_r == H_IDLE;
	assign doneValid = state_r == H_DONE;
	assign doneData = data_r;
	assign doneErr = err_r;

	always_comb begin
		bus.cmdOp = CMD_CTRL_RD;
		bus.cmdData = 16'h0000;
		follow = H_IDLE;
		case (state_r)
			H_PAGE: begin
				bus.cmdOp = CMD_PAGE_WR;
				bus.cmdData = {8'h00, addr_r[23:16]};
				follow = kind_r == JOB_READ ? H_RDL : kind_r == JOB_ALL ? H_CFG : H_TWL;
			end
			H_TWL: begin
				// For block erase this write only names the block base
				bus.cmdOp = CMD_WR_LOW;
				bus.cmdData = needWord ? wordData[15:0] : 16'h0000;
				follow = kind_r == JOB_PROG ? H_TWH : H_CFG;
			end
			H_TWH: begin
				bus.cmdOp = CMD_WR_HIGH;
				bus.cmdData = {8'h00, data_r[23:16]};
				follow = cnt_r == 6'h3f ? H_CFG : H_TWL;
			end
			H_CFG: begin
				bus.cmdOp = CMD_CTRL_WR;
				bus.cmdData = ctrlWord(kind_r, 1'b0);
				follow = H_KEY1;
			end
			H_KEY1: begin
				bus.cmdOp = CMD_KEY_WR;
				bus.cmdData = {8'h00, KEY_FIRST};
				follow = H_KEY2;
			end
			H_KEY2: begin
				bus.cmdOp = CMD_KEY_WR;
				bus.cmdData = {8'h00, KEY_SECOND};
				follow = H_GO;
			end
			H_GO: begin
				bus.cmdOp = CMD_CTRL_WR;
				bus.cmdData = ctrlWord(kind_r, 1'b1);
				follow = H_CHK;
			end
			H_CHK: follow = H_DONE;
			H_RDL: begin
				bus.cmdOp = CMD_RD_LOW;
				follow = H_RDH;
			end
			H_RDH: begin
				bus.cmdOp = CMD_RD_HIGH;
				follow = H_DONE;
			end
			default: follow = H_IDLE;
		endcase
		if (state_r == H_IDLE) begin
			state_nxt = jobValid ? H_PAGE : H_IDLE;
		end else if (state_r == H_DONE) begin
			state_nxt = H_IDLE;
		end else begin
			state_nxt = step ? follow : state_r;
		end
	end

	// ---------------------------------------------------------------
	// Job state
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= H_IDLE;
			kind_r <= JOB_READ;
			pend_r <= 1'b0;
			addr_r <= 24'h000000;
			data_r <= 24'h000000;
			cnt_r <= 6'h00;
			err_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (issued) begin
				pend_r <= 1'b1;
			end else if (step) begin
				pend_r <= 1'b0;
			end
			if (state_r == H_IDLE && jobValid) begin
				kind_r <= jobKind;
				cnt_r <= 6'h00;
				err_r <= 1'b0;
				// Rows and blocks start on their own boundaries
				addr_r <= jobKind == JOB_PROG ? (jobAddr & ROW_ALIGN_MASK)
					: jobKind == JOB_BLK ? (jobAddr & BLK_ALIGN_MASK) : jobAddr;
			end
			if (wordReady) begin
				data_r <= wordData;
			end
			if (step && state_r == H_TWH) begin
				addr_r <= addr_r + ADDR_STEP;
				cnt_r <= cnt_r + 6'h01;
			end
			if (step && state_r == H_RDL) begin
				data_r[15:0] <= bus.rspData;
			end
			if (step && state_r == H_RDH) begin
				data_r[23:16] <= bus.rspData[7:0];
			end
			if (step && state_r == H_CHK) begin
				err_r <= bus.rspData[ERR_POS];
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/fspc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_chk #(
	parameter int OP_CYCLES = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire fspc_pkg::fspc_cmd_t cmdOp,
	input wire logic [15:0] cmdData,
	input wire logic rspValid,
	input wire logic [15:0] rspData,
	input wire logic mapSuspend,
	input wire logic cpuStall
);
	import fspc_pkg::*;
	// ---------------------------------------------------------------
	// Helper decode
	// ---------------------------------------------------------------
	logic [1:0] keyStage_r;
	logic [31:0] stallRun_r;
	wire logic take = cmdValid && cmdReady;
	wire logic isKey = take && cmdOp == CMD_KEY_WR;
	wire logic tableTake = take && cmdOp inside {CMD_RD_LOW, CMD_RD_HIGH, CMD_WR_LOW, CMD_WR_HIGH};
	wire logic startReq = take && cmdOp == CMD_CTRL_WR && cmdData[START_POS];
	wire logic pairOk = cmdData[ERASE_POS] ? (cmdData[3:0] == OP_BULK || cmdData[3:0] == OP_ROW_ERASE)
		: cmdData[3:0] == OP_ROW_PROG;
	wire logic goodStart = startReq && keyStage_r == 2'h2 && cmdData[PROGRAM_ERASE_ENABLE_POS] && pairOk;
	// Any other command between the keys disarms them
	wire logic [1:0] keyStage_nxt = (isKey && cmdData[7:0] == KEY_FIRST) ? 2'h1
		: (isKey && cmdData[7:0] == KEY_SECOND && keyStage_r == 2'h1) ? 2'h2 : 2'h0;
	wire logic [31:0] stallRun_nxt = cpuStall ? stallRun_r + 32'h1 : 32'h0;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			keyStage_r <= 2'h0;
			stallRun_r <= 32'h0;
		end else begin
			keyStage_r <= take ? keyStage_nxt : keyStage_r;
			stallRun_r <= stallRun_nxt;
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_rsp_timing;
		take |=> rspValid;
	endproperty
	a_rsp_timing: assert property (p_rsp_timing) else $error("no answer after taken command");
	property p_rsp_cause;
		rspValid |-> $past(take);
	endproperty
	a_rsp_cause: assert property (p_rsp_cause) else $error("answer without command");
	property p_table_walk;
		tableTake |-> mapSuspend ##1 (rspValid && mapSuspend && !cmdReady) ##1 cmdReady;
	endproperty
	a_table_walk: assert property (p_table_walk) else $error("table access not two cycles");
	property p_map_only_table;
		mapSuspend |-> tableTake || (rspValid && $past(tableTake));
	endproperty
	a_map_only_table: assert property (p_map_only_table) else $error("mapping paused outside table op");
	property p_stall_len;
		$fell(cpuStall) |-> stallRun_r == OP_CYCLES && cmdReady;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("operation length wrong");
	property p_stall_cap;
		cpuStall |-> stallRun_r < OP_CYCLES && !cmdReady;
	endproperty
	a_stall_cap: assert property (p_stall_cap) else $error("stall too long or bus open");
	property p_stall_cause;
		$rose(cpuStall) |-> $past(goodStart, 2);
	endproperty
	a_stall_cause: assert property (p_stall_cause) else $error("operation without valid start");
	property p_launch;
		goodStart |-> ##1 rspValid ##1 cpuStall;
	endproperty
	a_launch: assert property (p_launch) else $error("valid start not launched");
	property p_refuse;
		startReq && !goodStart |-> ##2 !cpuStall;
	endproperty
	a_refuse: assert property (p_refuse) else $error("improper start launched");
	property p_ctrl_read;
		rspValid && $past(cmdOp) == CMD_CTRL_RD |-> (rspData & 16'h9fb0) == 16'h0000;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read shows stray bits");
	c_launch: cover property (goodStart);
	c_finish: cover property ($fell(cpuStall));
	c_table_write: cover property (tableTake && cmdOp == CMD_WR_LOW);
endmodule
`default_nettype wire

// ### dv/test_flash_self_program_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_control;
	import fspc_pkg::*;
	localparam int OPC = 8;
	localparam int SPAN = 40 * (64 * 4 + 60 * (OPC + 4));
	logic clk_sys, rst, softRst, jobValid, wordValid;
	fspc_job_t jobKind;
	logic [23:0] jobAddr, wordData;
	logic jobReady, wordReady, doneValid, doneErr, cpuStall, mapSuspend, cpuStall2, mapSuspend2;
	logic [23:0] doneData;
	logic [25:0] hostQ[$];
	logic [16:0] rspQ[$];
	logic [23:0] words[64];
	logic [47:0] keyCases[6];
	int badCount, samplesChecked, wordIdx, k, stallCount, suspCount;
	integer seed = 32'hbac10ddc;
	fspc_if link();
	fspc_if probe();
	fspc_dev #(.ARRAY_ROWS(16), .OP_CYCLES(OPC)) fspc_dev_i (.clk_sys(clk_sys), .rst(rst), .softRst(1'h0),
		.bus(link.dev), .mapSuspend(mapSuspend), .cpuStall(cpuStall));
	fspc_host fspc_host_i (.clk_sys(clk_sys), .rst(rst), .bus(link.host), .jobValid(jobValid), .jobKind(jobKind),
		.jobAddr(jobAddr), .jobReady(jobReady), .wordValid(wordValid), .wordData(wordData),
		.wordReady(wordReady), .doneValid(doneValid), .doneData(doneData), .doneErr(doneErr));
	fspc_dev #(.ARRAY_ROWS(8), .OP_CYCLES(OPC)) fspc_dev_i2 (.clk_sys(clk_sys), .rst(rst), .softRst(softRst),
		.bus(probe.dev), .mapSuspend(mapSuspend2), .cpuStall(cpuStall2));
	fspc_chk #(.OP_CYCLES(OPC)) fspc_chk_i (.clk_sys(clk_sys), .rst(rst), .cmdValid(link.cmdValid),
		.cmdReady(link.cmdReady), .cmdOp(link.cmdOp), .cmdData(link.cmdData), .rspValid(link.rspValid),
		.rspData(link.rspData), .mapSuspend(mapSuspend), .cpuStall(cpuStall));
	initial begin
		clk_sys = 1'h0;
		forever #4 clk_sys = ~clk_sys;
	end
	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		samplesChecked++;
		if (got !== exp) begin
			badCount++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic completeRun();
		$display("checked %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Bit 25 marks a read job (data checked), else only the error flag
	always @(posedge clk_sys) begin
		if (doneValid === 1'h1 && hostQ.size() > 0) begin
			if (hostQ[0][25]) check("doneData", hostQ[0][23:0], doneData);
			else check("doneErr", {23'h0, hostQ[0][24]}, {23'h0, doneErr});
			void'(hostQ.pop_front());
		end
		if (probe.rspValid === 1'h1 && rspQ.size() > 0) begin
			if (rspQ[0][16]) check("rspData", {8'h0, rspQ[0][15:0]}, {8'h0, probe.rspData});
			void'(rspQ.pop_front());
		end
		if (wordValid && wordReady === 1'h1) wordIdx = wordIdx + 1;
		if (cpuStall2 === 1'h1) stallCount++;
		// Each table op on the probe should pause the window for exactly two cycles
		if (mapSuspend2 === 1'h1) suspCount++;
	end
	always @(negedge clk_sys) wordData <= words[wordIdx[5:0]];
	// ---------------------------------------------------------------
	// Drivers
	// ---------------------------------------------------------------
	task automatic job(input fspc_job_t kind, input logic [23:0] a, input logic [25:0] e);
		int n;
		hostQ.push_back(e);
		@(negedge clk_sys);
		jobValid = 1'h1;
		jobKind = kind;
		jobAddr = a;
		n = 0;
		do @(posedge clk_sys); while (jobReady !== 1'h1 && ++n < 20);
		@(negedge clk_sys);
		jobValid = 1'h0;
		for (n = 0; n < 1000 && jobReady !== 1'h1; n++) @(negedge clk_sys);
	endtask
	task automatic cmd(input fspc_cmd_t op, input logic [15:0] a, input logic b, input logic [15:0] d,
		input logic c, input logic [15:0] e);
		int n;
		rspQ.push_back({c, e});
		@(negedge clk_sys);
		probe.cmdValid = 1'h1;
		probe.cmdOp = op;
		probe.cmdAddr = a;
		probe.cmdByte = b;
		probe.cmdData = d;
		n = 0;
		do @(posedge clk_sys); while (probe.cmdReady !== 1'h1 && ++n < 50);
		@(negedge clk_sys);
		probe.cmdValid = 1'h0;
		probe.cmdData = ~d;
	endtask
	task automatic put(input fspc_cmd_t op, input logic [15:0] a, input logic [15:0] d);
		cmd(op, a, 1'h0, d, 1'h0, 16'h0);
	endtask
	task automatic ctl(input logic [15:0] e);
		cmd(CMD_CTRL_RD, 16'h0, 1'h0, 16'h0, 1'h1, e);
	endtask
	task automatic go(input logic [7:0] k1, input logic [7:0] k2, input logic [15:0] c);
		put(CMD_KEY_WR, 16'h0, {8'h0, k1});
		put(CMD_KEY_WR, 16'h0, {8'h0, k2});
		put(CMD_CTRL_WR, 16'h0, c);
	endtask
	initial begin
		repeat (SPAN) @(posedge clk_sys);
		badCount++;
		$display("watchdog expired");
		completeRun();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		rst = 1'h1;
		softRst = 1'h0;
		jobValid = 1'h0;
		jobKind = JOB_READ;
		jobAddr = 24'h0;
		wordValid = 1'h0;
		wordData = 24'h0;
		probe.cmdValid = 1'h0;
		probe.cmdOp = CMD_CTRL_RD;
		probe.cmdAddr = 16'h0;
		probe.cmdByte = 1'h0;
		probe.cmdData = 16'h0;
		keyCases = '{48'h55aa80012001, 48'haa55c0016001, 48'h55aac00f400f, 48'h55aac0414041, 48'h55aac0454045,
			48'h55aac0024002};
		for (int i = 0; i < 64; i++) words[i] = 24'($random(seed));
		repeat (8) @(negedge clk_sys);
		rst = 1'h0;
		job(JOB_ALL, 24'h0, 26'h0);
		wordValid = 1'h1;
		job(JOB_PROG, 24'h000400, 26'h0);
		wordValid = 1'h0;
		check("words taken", 24'h40, 24'(wordIdx));
		for (int i = 0; i < 3; i++) begin
			k = (i == 0) ? 0 : (i == 1) ? 63 : ($random(seed) & 63);
			job(JOB_READ, 24'h000400 + 24'(2 * k), {2'h2, words[k]});
		end
		job(JOB_BLK, 24'h0, 26'h0);
		job(JOB_READ, 24'h000400, {2'h2, words[0]});
		job(JOB_BLK, 24'h000400, 26'h0);
		job(JOB_READ, 24'h00047e, {2'h2, ERASED_WORD});
		$display("host job test done");
		ctl(16'h0000);
		put(CMD_CTRL_WR, 16'h0, 16'h7fff);
		ctl(16'h604f);
		@(negedge clk_sys);
		softRst = 1'h1;
		@(negedge clk_sys);
		softRst = 1'h0;
		ctl(16'h604f);
		put(CMD_CTRL_WR, 16'h0, 16'h4001);
		put(CMD_CTRL_WR, 16'h0, 16'hc001);
		ctl(16'h6001);
		foreach (keyCases[i]) begin
			k = stallCount;
			go(keyCases[i][47:40], keyCases[i][39:32], keyCases[i][31:16]);
			ctl(keyCases[i][15:0]);
			check("no launch", 24'h0, 24'(stallCount - k));
		end
		$display("refusal test done");
		k = stallCount;
		go(8'h55, 8'haa, 16'hc04f);
		ctl(16'h404f);
		check("stall cycles", 24'(OPC), 24'(stallCount - k));
		put(CMD_PAGE_WR, 16'h0, 16'h0000);
		put(CMD_WR_LOW, 16'h0100, 16'h1234);
		put(CMD_WR_HIGH, 16'h0100, 16'h0056);
		cmd(CMD_RD_LOW, 16'h0100, 1'h0, 16'h0, 1'h1, 16'hffff);
		go(8'h55, 8'haa, 16'hc001);
		cmd(CMD_RD_LOW, 16'h0100, 1'h0, 16'h0, 1'h1, 16'h1234);
		cmd(CMD_RD_LOW, 16'h0101, 1'h1, 16'h0, 1'h1, 16'h0012);
		cmd(CMD_RD_HIGH, 16'h0100, 1'h0, 16'h0, 1'h1, 16'h0056);
		cmd(CMD_RD_HIGH, 16'h0101, 1'h1, 16'h0, 1'h1, 16'h0000);
		put(CMD_PAGE_WR, 16'h0, 16'h0001);
		cmd(CMD_RD_LOW, 16'h0100, 1'h0, 16'h0, 1'h1, 16'h0000);
		put(CMD_PAGE_WR, 16'h0, 16'h0000);
		check("suspend cycles", 24'h10, 24'(suspCount));
		$display("table access test done");
		// New buffer data, so a row written despite the abort would show
		put(CMD_WR_LOW, 16'h0100, 16'hbeef);
		go(8'h55, 8'haa, 16'hc001);
		repeat (3) @(negedge clk_sys);
		softRst = 1'h1;
		@(negedge clk_sys);
		softRst = 1'h0;
		ctl(16'h6001);
		cmd(CMD_RD_LOW, 16'h0100, 1'h0, 16'h0, 1'h1, 16'h1234);
		repeat (4) @(negedge clk_sys);
		check("pending", 24'h0, 24'(hostQ.size() + rspQ.size()));
		$display("abort test done");
		completeRun();
	end
endmodule
`default_nettype wire
